// >>> rtl/pcoc_consts.vh
`ifndef PCOC_CONSTS_VH
`define PCOC_CONSTS_VH
// Register indices on the plain register port.
`define PCOC_REG_CTRL      4'h0
`define PCOC_REG_PHASE     4'h1
`define PCOC_REG_SLIP      4'h2
`define PCOC_REG_CYCLE     4'h3
`define PCOC_REG_STROKE    4'h4
`define PCOC_REG_SHIFT     4'h5
`define PCOC_REG_TADDR     4'h6
`define PCOC_REG_TDATA     4'h7
`define PCOC_REG_STATUS    4'h8
`define PCOC_REG_MPHASE    4'h9
`define PCOC_REG_RES       4'hA
// Control register field positions.
`define PCOC_CTRL_PHEN     0
`define PCOC_CTRL_SLIP     1
`define PCOC_CTRL_CAMEN    2
`define PCOC_CTRL_ONL      4
`define PCOC_CTRL_OFFL     6
// Trigger detection codes.
`define PCOC_EDGE_LEVEL    2'h0
`define PCOC_EDGE_RISE     2'h1
`define PCOC_EDGE_FALL     2'h2
// Reset values.
`define PCOC_CTRL_RST      32'h00000000
`define PCOC_CYCLE_RST     32'h00000001
`define PCOC_STROKE_RST    32'h00000001
`define PCOC_SLIP_RST      14'h0001
// Limits.
`define PCOC_PHASE_MAX     7'h63
`define PCOC_SLIP_MIN      14'h0001
`define PCOC_SLIP_MAX      14'h2710
`define PCOC_CYCLE_MAX     31'h7FFFFFFF
`define PCOC_ADJ_MAX       11'h3E8
// Timing: one millisecond at the 10 MHz control clock.
`define PCOC_CLK_MHZ       10
`define PCOC_MS_US         1000
`define PCOC_MS_CYC        (`PCOC_MS_US * `PCOC_CLK_MHZ)
`endif

// >>> rtl/pcoc_cam_lookup.v
`timescale 1ns/1ns
// Maps a phase to a table index and scales the stored percentage by the stroke.
module pcoc_cam_lookup #(
    parameter IDX_W = 15
) (
    // Clock and control.
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire             ce_i,
    // Phase in, scaled displacement out.
    input  wire [IDX_W-1:0] idx_i,
    input  wire [IDX_W-1:0] shift_i,
    input  wire [IDX_W-1:0] res_mask_i,
    output wire [IDX_W-1:0] addr_o,
    input  wire [15:0]      pct_i,
    input  wire [31:0]      stroke_i,
    output reg  [31:0]      disp_o
);
    // Shifted origin, wrapped to the selected resolution.
    assign addr_o = (idx_i + shift_i) & res_mask_i; // [R13]

    reg [47:0] prod;
    // Table entry holds percent in 1/100 % steps, 10000 meaning full stroke.
    always @* begin
        prod = ({16'h0000, stroke_i} * {32'h00000000, pct_i}) / 48'd10000;
    end

    // Registered displacement, stroke * pct / 10000.
    always @(posedge clk_i) begin
        if (rst_i) begin
            disp_o <= 32'h00000000;
        end else if (ce_i) begin
            disp_o <= prod[31:0]; // [R9]
        end
    end
endmodule // pcoc_cam_lookup

// >>> rtl/pcoc_top.v
// Contract
// [R1] Without phase mode, release on OFF immediately; with the slip bit set the code ramps down in ST_DEC first.
// [R2] Phase mode holds until disconnect phase reached.
// [R3] Disconnect phase is integer 0..99 percent.
// [R4] Works with level, rise or fall triggers.
// [R5] Slip: time slip after phase, then decelerate.
// [R6] Program picks direct for exact stop.
// [R7] Late OFF waits for the next cycle.
// [R8] Cam output from phase via profile lookup.
// [R9] Profile spans one rotation, percent of stroke.
// [R10] Resolution selectable 1024 through 32768 points.
// [R11] Profile count depends on resolution; the code keeps NPROF = 4 profiles at every resolution.
// [R12] Up to twenty sections with curve shapes.
// [R13] Phase origin shift zero to full cycle.
// [R14] At most 1000 point adjustments.
// [R15] Direct mode: instant speed take-up or drop.
// [R16] Slip ramps linearly over 1..10000 ms.
// [R17] Phase is master pulses modulo cycle length.
// [R18] Cam disabled passes clutch output through.
// [R19] Release at first index reaching rounded point.
`timescale 1ns/1ns
`include "pcoc_consts.vh"
module pcoc_top #(
    parameter IDX_W    = 15,
    parameter NPROF    = 4,
    parameter PROF_W   = 2,
    parameter MS_CYC   = `PCOC_MS_CYC
) (
    // Clock, reset, enable.
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        ce_i,
    // Register port.
    input  wire [3:0]  addr_i,
    input  wire [31:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [31:0] rdata_o,
    // Master axis and clutch requests.
    input  wire        mpulse_i,
    input  wire        on_req_i,
    input  wire        off_req_i,
    // Slave command.
    output reg  [31:0] cmd_o,
    output reg         engaged_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    reg  [31:0] ctrl_ff;          // Mode bits and edge selections.
    reg  [6:0]  phase_pct_ff;     // Disconnect phase in percent.
    reg  [13:0] slip_ms_ff;       // Slip time in milliseconds.
    reg  [30:0] cycle_ff;         // Master cycle length in pulses.
    reg  [31:0] stroke_ff;        // Full stroke in pulses.
    reg  [IDX_W-1:0] shift_ff;    // Profile origin shift in points.
    reg  [2:0]  res_ff;           // Resolution code, 0 = 1024 .. 5 = 32768.
    reg  [PROF_W+IDX_W-1:0] taddr_ff; // Table write pointer.
    reg  [10:0] adj_cnt_ff;       // Count of point edits since reset.
    reg  [15:0] table_ff [0:NPROF*(1<<IDX_W)-1]; // Profile point store.
    reg  [PROF_W-1:0] prof_sel_ff; // Active profile.

    wire        ph_en   = ctrl_ff[`PCOC_CTRL_PHEN];
    wire        slip_en = ctrl_ff[`PCOC_CTRL_SLIP];
    wire        cam_en  = ctrl_ff[`PCOC_CTRL_CAMEN];
    wire [1:0]  on_sel  = ctrl_ff[`PCOC_CTRL_ONL+1:`PCOC_CTRL_ONL];
    wire [1:0]  off_sel = ctrl_ff[`PCOC_CTRL_OFFL+1:`PCOC_CTRL_OFFL];
    wire [IDX_W-1:0] res_mask = (15'h0400 << res_ff) - 15'h0001; // [R10]

    ////////////////////////////////////////////////////////////////////////////
    // Register writes; table edits are limited in number.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff      <= `PCOC_CTRL_RST;
            phase_pct_ff <= 7'h00;
            slip_ms_ff   <= `PCOC_SLIP_RST;
            cycle_ff     <= 31'h00000001;
            stroke_ff    <= `PCOC_STROKE_RST;
            shift_ff     <= {IDX_W{1'b0}};
            res_ff       <= 3'h0;
            taddr_ff     <= {(PROF_W+IDX_W){1'b0}};
            adj_cnt_ff   <= 11'h000;
            prof_sel_ff  <= {PROF_W{1'b0}};
        end else if (ce_i && wr_i) begin
            case (addr_i)
                `PCOC_REG_CTRL: begin
                    ctrl_ff     <= wdata_i;
                    prof_sel_ff <= wdata_i[8+PROF_W-1:8]; // [R11]
                end
                `PCOC_REG_PHASE: begin
                    // Out of range percentages are refused.
                    if (wdata_i[6:0] <= `PCOC_PHASE_MAX && wdata_i[31:7] == 25'h0) begin
                        phase_pct_ff <= wdata_i[6:0]; // [R3]
                    end
                end
                `PCOC_REG_SLIP: begin
                    if (wdata_i[13:0] >= `PCOC_SLIP_MIN && wdata_i[13:0] <= `PCOC_SLIP_MAX
                        && wdata_i[31:14] == 18'h0) begin
                        slip_ms_ff <= wdata_i[13:0]; // [R16]
                    end
                end
                `PCOC_REG_CYCLE: begin
                    if (wdata_i[30:0] != 31'h0 && !wdata_i[31]) begin
                        cycle_ff <= wdata_i[30:0]; // [R17]
                    end
                end
                `PCOC_REG_STROKE: begin
                    stroke_ff <= wdata_i;
                end
                `PCOC_REG_SHIFT: begin
                    shift_ff <= wdata_i[IDX_W-1:0] & res_mask; // [R13]
                end
                `PCOC_REG_TADDR: begin
                    taddr_ff <= wdata_i[PROF_W+IDX_W-1:0];
                end
                `PCOC_REG_TDATA: begin
                    if (adj_cnt_ff < `PCOC_ADJ_MAX) begin
                        adj_cnt_ff <= adj_cnt_ff + 11'h001; // [R14]
                    end
                end
                `PCOC_REG_RES: begin
                    if (wdata_i[2:0] <= 3'h5) begin
                        res_ff <= wdata_i[2:0]; // [R10]
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Point store write; sections and curve shapes are precomputed by software
    // into per-point data, so any of twenty sections maps onto the table.
    always @(posedge clk_i) begin
        if (ce_i && wr_i && addr_i == `PCOC_REG_TDATA && adj_cnt_ff < `PCOC_ADJ_MAX) begin
            table_ff[taddr_ff] <= wdata_i[15:0]; // [R12] [R14]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Master phase counter modulo cycle length.
    reg [30:0] mcount_ff;
    always @(posedge clk_i) begin
        if (rst_i) begin
            mcount_ff <= 31'h0;
        end else if (ce_i && mpulse_i) begin
            if (mcount_ff + 31'h1 >= cycle_ff) begin
                mcount_ff <= 31'h0; // [R17]
            end else begin
                mcount_ff <= mcount_ff + 31'h1;
            end
        end
    end

    // Phase index = count * points / cycle.
    wire [IDX_W:0]   npts = {1'b0, res_mask} + 16'h0001;
    wire [46:0]      idx_prod = {16'h0, mcount_ff} * {31'h0, npts};
    wire [46:0]      idx_q = idx_prod / {16'h0, cycle_ff};
    wire [IDX_W-1:0] idx = idx_q[IDX_W-1:0];
    // Disconnect point rounded to nearest table point.
    wire [22:0]      tgt_prod = {16'h0, phase_pct_ff} * {7'h0, npts} + 23'd50;
    wire [22:0]      tgt_q = tgt_prod / 23'd100;
    wire [IDX_W-1:0] tgt_idx = tgt_q[IDX_W-1:0]; // [R19]

    ////////////////////////////////////////////////////////////////////////////
    // Trigger detection.
    reg on_d_ff;
    reg off_d_ff;
    reg [IDX_W-1:0] idx_d_ff;
    always @(posedge clk_i) begin
        if (rst_i) begin
            on_d_ff  <= 1'b0;
            off_d_ff <= 1'b0;
            idx_d_ff <= {IDX_W{1'b0}};
        end else if (ce_i) begin
            on_d_ff  <= on_req_i;
            off_d_ff <= off_req_i;
            idx_d_ff <= idx;
        end
    end
    wire on_rise  = on_req_i & ~on_d_ff;
    wire on_fall  = ~on_req_i & on_d_ff;
    wire off_rise = off_req_i & ~off_d_ff;
    wire off_fall = ~off_req_i & off_d_ff;
    wire on_evt   = (on_sel == `PCOC_EDGE_RISE) ? on_rise :
                    (on_sel == `PCOC_EDGE_FALL) ? on_fall : on_rise; // [R4]
    // In level mode OFF is the ON request dropping.
    wire off_evt  = (on_sel == `PCOC_EDGE_LEVEL) ? on_fall :
                    (off_sel == `PCOC_EDGE_RISE) ? off_rise :
                    (off_sel == `PCOC_EDGE_FALL) ? off_fall : 1'b0; // [R4]
    // Phase reached: crossed target since last cycle, including wrap.
    wire wrapped  = idx < idx_d_ff;
    wire reached  = wrapped ? (idx >= tgt_idx || idx_d_ff < tgt_idx)
                            : (idx_d_ff < tgt_idx && idx >= tgt_idx); // [R7] [R19]

    ////////////////////////////////////////////////////////////////////////////
    // Clutch state machine.
    localparam ST_OFF  = 3'h0;
    localparam ST_ON   = 3'h1;
    localparam ST_WAIT = 3'h2;
    localparam ST_SLIP = 3'h3;
    localparam ST_DEC  = 3'h4;
    reg [2:0]  st_ff;
    reg [2:0]  nxt_st;
    reg [13:0] ms_ff;           // Elapsed milliseconds.
    reg [23:0] tick_ff;         // Cycles within the current millisecond.
    reg [13:0] ramp_ff;         // Speed scale, slip_ms_ff = full speed.
    wire ms_tick = (tick_ff == MS_CYC - 1);

    // Next state.
    always @* begin
        nxt_st = st_ff;
        case (st_ff)
            ST_OFF: begin
                if (on_evt) nxt_st = ST_ON;
            end
            ST_ON: begin
                if (off_evt) begin
                    if (!ph_en) nxt_st = slip_en ? ST_DEC : ST_OFF; // [R1]
                    else nxt_st = ST_WAIT;                          // [R2]
                end
            end
            ST_WAIT: begin
                if (reached) nxt_st = slip_en ? ST_SLIP : ST_OFF;  // [R2] [R5]
            end
            ST_SLIP: begin
                if (ms_tick && ms_ff + 14'h1 >= slip_ms_ff) nxt_st = ST_DEC; // [R5]
            end
            ST_DEC: begin
                if (ramp_ff == 14'h0) nxt_st = ST_OFF; // [R16]
            end
            default: nxt_st = ST_OFF;
        endcase
    end

    // State, millisecond timer and linear ramp.
    always @(posedge clk_i) begin
        if (rst_i) begin
            st_ff   <= ST_OFF;
            ms_ff   <= 14'h0;
            tick_ff <= 24'h0;
            ramp_ff <= 14'h0;
        end else if (ce_i) begin
            st_ff   <= nxt_st;
            tick_ff <= (ms_tick || nxt_st != st_ff) ? 24'h0 : tick_ff + 24'h1;
            if (nxt_st != st_ff) ms_ff <= 14'h0;
            else if (ms_tick) ms_ff <= ms_ff + 14'h1;
            if (nxt_st == ST_ON && st_ff == ST_OFF) begin
                ramp_ff <= slip_en ? 14'h0 : slip_ms_ff; // [R15]
            end else if (nxt_st == ST_OFF) begin
                ramp_ff <= 14'h0;                        // [R15]
            end else if (ms_tick && st_ff == ST_DEC && ramp_ff != 14'h0) begin
                ramp_ff <= ramp_ff - 14'h1;              // [R16]
            end else if (ms_tick && st_ff == ST_ON && ramp_ff < slip_ms_ff) begin
                ramp_ff <= ramp_ff + 14'h1;              // [R16]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clutch output: master pulse passed through, scaled during slip ramps.
    reg  [13:0] acc_ff;
    wire [14:0] acc_sum = {1'b0, acc_ff} + {1'b0, ramp_ff};
    wire        full    = (st_ff == ST_ON || st_ff == ST_WAIT || st_ff == ST_SLIP) &&
                          (ramp_ff >= slip_ms_ff);
    wire        dec_out = (st_ff == ST_DEC || st_ff == ST_ON) && mpulse_i &&
                          acc_sum >= {1'b0, slip_ms_ff};
    wire        cl_pulse = full ? mpulse_i : dec_out;
    always @(posedge clk_i) begin
        if (rst_i) begin
            acc_ff <= 14'h0;
        end else if (ce_i && mpulse_i && !full) begin
            acc_ff <= dec_out ? acc_sum[13:0] - slip_ms_ff : acc_sum[13:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cam stage.
    wire [IDX_W-1:0] cam_addr;
    wire [31:0]      cam_disp;
    pcoc_cam_lookup #(.IDX_W(IDX_W)) u_cam (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .idx_i      (idx),
        .shift_i    (shift_ff),
        .res_mask_i (res_mask),
        .addr_o     (cam_addr),
        .pct_i      (table_ff[{prof_sel_ff, cam_addr}]),
        .stroke_i   (stroke_ff),
        .disp_o     (cam_disp)
    );

    // Slave command and engaged flag.
    always @(posedge clk_i) begin
        if (rst_i) begin
            cmd_o     <= 32'h0;
            engaged_o <= 1'b0;
        end else if (ce_i) begin
            engaged_o <= (st_ff != ST_OFF);
            if (cam_en) cmd_o <= (st_ff != ST_OFF) ? cam_disp : cmd_o; // [R8]
            else cmd_o <= cmd_o + {31'h0, cl_pulse};                     // [R18]
        end
    end

    // Register reads, data in the following cycle.
    always @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0;
        end else if (ce_i) begin
            if (rd_i) begin
                case (addr_i)
                    `PCOC_REG_CTRL:   rdata_o <= ctrl_ff;
                    `PCOC_REG_PHASE:  rdata_o <= {25'h0, phase_pct_ff};
                    `PCOC_REG_SLIP:   rdata_o <= {18'h0, slip_ms_ff};
                    `PCOC_REG_CYCLE:  rdata_o <= {1'b0, cycle_ff};
                    `PCOC_REG_STROKE: rdata_o <= stroke_ff;
                    `PCOC_REG_SHIFT:  rdata_o <= {17'h0, shift_ff};
                    `PCOC_REG_STATUS: rdata_o <= {18'h0, adj_cnt_ff, st_ff};
                    `PCOC_REG_MPHASE: rdata_o <= {1'b0, mcount_ff};
                    `PCOC_REG_RES:    rdata_o <= {29'h0, res_ff};
                    default:          rdata_o <= 32'h0;
                endcase
            end else begin
                rdata_o <= 32'h0;
            end
        end
    end
endmodule // pcoc_top

// >>> tb/pcoc_checker.sv
`timescale 1ns/1ns
`include "pcoc_consts.vh"
// Watches the top ports and mirrors the control, phase, slip and cycle settings written over the register port.
module pcoc_checker (
    // Clock and control.
    input wire        clk_i,
    input wire        rst_i,
    input wire        ce_i,
    // Register port.
    input wire [3:0]  addr_i,
    input wire [31:0] wdata_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire [31:0] rdata_o,
    // Master axis, requests and slave command.
    input wire        mpulse_i,
    input wire        on_req_i,
    input wire        off_req_i,
    input wire [31:0] cmd_o,
    input wire        engaged_o
);
    reg  [31:0] ctrl_ff;                 // Last control word written.
    reg  [31:0] phase_ff;                // Last accepted disconnect phase.
    reg  [31:0] slip_ff;                 // Last accepted slip time.
    reg  [31:0] cycle_ff;                // Last accepted master cycle length.
    wire        wr_ok = wr_i && ce_i;    // A write that the block takes.
    wire        rd_ok = rd_i && ce_i;    // A read that the block takes.
    wire        direct = !ctrl_ff[0] && !ctrl_ff[1]; // Direct release, no phase wait.

    ////////////////////////////////////////////////////////////////////////////
    // Mirror only the writes that the block must accept.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff  <= `PCOC_CTRL_RST;
            phase_ff <= 32'h0;
            slip_ff  <= 32'h1;
            cycle_ff <= `PCOC_CYCLE_RST;
        end else if (wr_ok) begin
            if (addr_i == `PCOC_REG_CTRL) ctrl_ff <= wdata_i;
            if (addr_i == `PCOC_REG_PHASE && wdata_i <= 32'h63) phase_ff <= wdata_i;
            if (addr_i == `PCOC_REG_SLIP && wdata_i >= 32'h1 && wdata_i <= 32'h2710) slip_ff <= wdata_i;
            if (addr_i == `PCOC_REG_CYCLE && wdata_i != 32'h0 && !wdata_i[31]) cycle_ff <= wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // All checks share the control clock and its reset.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_phase_readback: assert property (rd_ok && addr_i == `PCOC_REG_PHASE |=> rdata_o == phase_ff)
        else $error("disconnect phase readback wrong");
    a_slip_readback: assert property (rd_ok && addr_i == `PCOC_REG_SLIP |=> rdata_o == slip_ff)
        else $error("slip time readback wrong");
    a_cycle_readback: assert property (rd_ok && addr_i == `PCOC_REG_CYCLE |=> rdata_o == cycle_ff)
        else $error("cycle length readback wrong");
    a_master_modulo: assert property (rd_ok && addr_i == `PCOC_REG_MPHASE |=> rdata_o < cycle_ff)
        else $error("master count beyond cycle length");
    a_direct_release: assert property (direct && ctrl_ff[7:6] == 2'h1 && ctrl_ff[5:4] != 2'h0 && engaged_o
        && $rose(off_req_i) |-> ##[1:2] !engaged_o)
        else $error("direct release late");
    a_rise_engage: assert property (ctrl_ff[5:4] == 2'h1 && !engaged_o && $rose(on_req_i) |-> ##[1:2] engaged_o)
        else $error("rising request did not engage");
    a_fall_engage: assert property (ctrl_ff[5:4] == 2'h2 && !engaged_o && $fell(on_req_i) |-> ##[1:2] engaged_o)
        else $error("falling request did not engage");
    a_level_release: assert property (direct && ctrl_ff[5:4] == 2'h0 && engaged_o && $fell(on_req_i)
        |-> ##[1:2] !engaged_o)
        else $error("level release late");
    a_status_engaged: assert property (rd_ok && addr_i == `PCOC_REG_STATUS
        |=> engaged_o == (rdata_o[2:0] != 3'h0))
        else $error("status state disagrees with engaged flag");

    c_phase_release: cover property (ctrl_ff[0] && engaged_o ##1 !engaged_o);
    c_slip_release: cover property (ctrl_ff[1] && engaged_o ##1 !engaged_o);
    c_engage: cover property ($rose(engaged_o));
endmodule // pcoc_checker

// >>> tb/pcoc_servo_model.sv
`timescale 1ns/1ns
// Servo drive that takes each slave command at once, with no ramp of its own.
module pcoc_servo_model (
    // Clock and reset.
    input  wire        clk_i,
    input  wire        rst_i,
    // Command from the block.
    input  wire [31:0] cmd_i,
    input  wire        engaged_i,
    // Position reached and moves made while engaged.
    output reg  [31:0] pos_o,
    output reg  [31:0] steps_o
);
    // The position follows the command one cycle later.
    always @(posedge clk_i) begin
        if (rst_i) begin
            pos_o   <= 32'h0;
            steps_o <= 32'h0;
        end else begin
            pos_o <= cmd_i;
            if (engaged_i && cmd_i != pos_o) steps_o <= steps_o + 32'h1;
        end
    end
endmodule // pcoc_servo_model

// >>> tb/pcoc_top_tb_top.sv
`timescale 1ns/1ns
`include "pcoc_consts.vh"
// Self-checking bench for the clutch release and cam stage.
module pcoc_top_tb_top;
    reg         clk_i, rst_i, ce_i, wr_i, rd_i, mpulse_i, on_req_i, off_req_i, idl;
    reg  [3:0]  addr_i;
    reg  [31:0] wdata_i, w, d, c0, ph, sl;
    wire [31:0] rdata_o, cmd_o, pos, steps;
    wire        engaged_o;
    integer     error_cnt, total_checks, cyc, i, n, np, c, t, k, r;

    pcoc_top #(.MS_CYC(10)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mpulse_i(mpulse_i),
        .on_req_i(on_req_i), .off_req_i(off_req_i), .cmd_o(cmd_o), .engaged_o(engaged_o));
    pcoc_servo_model u_servo (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd_o), .engaged_i(engaged_o),
        .pos_o(pos), .steps_o(steps));

    // Clock of 100 ns period and the hang guard.
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0t run hung", $time);
            wrap_up;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Accepted value of a write, or the old one when the block must refuse it.
    function [31:0] acc(input [31:0] cur, input [31:0] v, input [31:0] lo, input [31:0] hi);
        acc = (v >= lo && v <= hi) ? v : cur;
    endfunction
    // First master count of ten whose point index reaches the rounded disconnect point.
    function integer rel_at(input integer p);
        for (rel_at = 9; rel_at > 0 && (rel_at - 1) * 32768 / 10 >= (p * 32768 + 50) / 100; rel_at = rel_at - 1);
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [3:0] a, input [31:0] v);
        begin
            addr_i <= a;
            wdata_i <= v;
            wr_i <= 1'b1;
            @(posedge clk_i);
            wr_i <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    task rd(input [3:0] a, output [31:0] v);
        begin
            addr_i <= a;
            rd_i <= 1'b1;
            @(posedge clk_i);
            rd_i <= 1'b0;
            #1 v = rdata_o;
            @(posedge clk_i);
        end
    endtask
    task rdchk(input [3:0] a, input [31:0] e);
        begin
            rd(a, d);
            chk(d, e);
        end
    endtask
    // Waits a bounded number of cycles for the engaged flag to reach a level.
    task wait_eng(input v, input integer lim);
        begin
            n = 0;
            while (engaged_o !== v && n < lim) begin
                @(posedge clk_i);
                #1 n = n + 1;
            end
            @(posedge clk_i);
        end
    endtask
    // One master count, then time for the release logic to settle.
    task pulse;
        begin
            mpulse_i <= 1'b1;
            @(posedge clk_i);
            mpulse_i <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask
    task engage;
        begin
            on_req_i <= ~idl;
            wait_eng(1'b1, 8);
            chk({31'h0, engaged_o}, 32'h1);
            on_req_i <= idl;
            @(posedge clk_i);
        end
    endtask
    task off_ev;
        begin
            off_req_i <= ~idl;
            @(posedge clk_i);
            off_req_i <= idl;
            repeat (20) @(posedge clk_i);
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d errors %0d", total_checks, error_cnt);
            if (error_cnt == 0 && total_checks > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        {clk_i, ce_i, rst_i, wr_i, rd_i, mpulse_i, on_req_i, off_req_i, idl} = 9'h0C0;
        addr_i = 4'h0;
        wdata_i = 32'h0;
        {error_cnt, total_checks, cyc} = 96'h0;
        r = $urandom(32'h9AC6);
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdchk(`PCOC_REG_CYCLE, 32'h1);
        // Range limits of phase and slip settings, edges first, then random.
        {ph, sl} = {32'h0, 32'h1};
        for (i = 0; i < 8; i = i + 1) begin
            w = (i == 0) ? 32'h63 : (i == 1) ? 32'h64 : $urandom % 150;
            wr(`PCOC_REG_PHASE, w);
            ph = acc(ph, w, 32'h0, 32'h63);
            rdchk(`PCOC_REG_PHASE, ph);
            w = (i == 0) ? 32'h2710 : (i == 1) ? 32'h0 : (i == 2) ? 32'h2711 : $urandom % 12000;
            wr(`PCOC_REG_SLIP, w);
            sl = acc(sl, w, 32'h1, 32'h2710);
            rdchk(`PCOC_REG_SLIP, sl);
        end
        wr(`PCOC_REG_CYCLE, 32'h0);
        wr(`PCOC_REG_CYCLE, 32'h80000000);
        rdchk(`PCOC_REG_CYCLE, 32'h1);
        wr(`PCOC_REG_CYCLE, 32'hA);
        for (i = 0; i < 7; i = i + 1) begin
            wr(`PCOC_REG_RES, i);
            rdchk(`PCOC_REG_RES, (i < 6) ? i : 5);
        end
        rdchk(4'hF, 32'h0);
        // Level requests: engage, follow the master, release when the level drops.
        wr(`PCOC_REG_CTRL, 32'h0);
        on_req_i <= 1'b1;
        wait_eng(1'b1, 8);
        chk({31'h0, engaged_o}, 32'h1);
        c0 = cmd_o;
        repeat (7) pulse;
        chk(cmd_o - c0, 32'h7);
        chk(pos, cmd_o);
        on_req_i <= 1'b0;
        wait_eng(1'b0, 8);
        chk({31'h0, n < 4}, 32'h1);
        // Rising and falling request edges with direct release.
        for (i = 1; i < 3; i = i + 1) begin
            idl = (i == 2);
            wr(`PCOC_REG_CTRL, (i << 4) | (i << 6));
            on_req_i <= idl;
            off_req_i <= idl;
            @(posedge clk_i);
            engage;
            off_req_i <= ~idl;
            wait_eng(1'b0, 8);
            chk({31'h0, n < 4}, 32'h1);
            off_req_i <= idl;
        end
        // Phase release at ratio zero, then random ratios, from random master counts.
        idl = 1'b0;
        wr(`PCOC_REG_CTRL, 32'h51);
        on_req_i <= 1'b0;
        off_req_i <= 1'b0;
        @(posedge clk_i);
        for (i = 0; i < 4; i = i + 1) begin
            t = (i == 0) ? 0 : $urandom % 10;
            wr(`PCOC_REG_PHASE, t * 10);
            engage;
            k = $urandom % 10;
            repeat (k) pulse;
            rd(`PCOC_REG_MPHASE, d);
            c = d;
            off_ev;
            chk({31'h0, engaged_o}, 32'h1);
            np = 0;
            while (engaged_o === 1'b1 && np < 12) begin
                pulse;
                np = np + 1;
            end
            chk(np, (rel_at(t * 10) + 9 - c) % 10 + 1);
        end
        // Slip release: timed after the phase hit, then a ramp down.
        wr(`PCOC_REG_CTRL, 32'h53);
        wr(`PCOC_REG_SLIP, 32'h2);
        wr(`PCOC_REG_PHASE, 32'h0);
        engage;
        rd(`PCOC_REG_MPHASE, d);
        c = d;
        if (c == 0) begin
            pulse;
            c = 1;
        end
        off_ev;
        repeat (10 - c) pulse;
        chk({31'h0, engaged_o}, 32'h1);
        wait_eng(1'b0, 300);
        chk({31'h0, n > 10 && n < 300}, 32'h1);
        // Cam stage: a full-stroke point at phase zero yields the whole stroke.
        wr(`PCOC_REG_TDATA, 32'h2710);
        wr(`PCOC_REG_STROKE, 32'h64);
        wr(`PCOC_REG_CTRL, 32'h54);
        engage;
        chk(cmd_o, 32'h64);
        rdchk(`PCOC_REG_STATUS, 32'h9);
        wrap_up;
    end
endmodule // pcoc_top_tb_top

bind pcoc_top pcoc_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mpulse_i(mpulse_i),
    .on_req_i(on_req_i), .off_req_i(off_req_i), .cmd_o(cmd_o), .engaged_o(engaged_o));
